// ===== logic/pcr_pkg.sv
package pcr_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 16;

  // Printed offsets carry a group tag in the top nibble
  localparam logic [15:0] TMS_OFFSET   = 16'h18f8;
  localparam logic [15:0] CSC_OFFSET   = 16'h3000;
  localparam logic [15:0] CSA_OFFSET   = 16'h38e6;
  localparam logic [15:0] CSS_OFFSET   = 16'h38e7;
  localparam logic [3:0]  TMS_TAG      = 4'h1;
  localparam logic [3:0]  CS_TAG       = 4'h3;

  // Interrupt registers
  localparam logic [11:0] IRQ_STAT_ADDR = 12'h100;
  localparam logic [11:0] IRQ_CLR_ADDR  = 12'h101;
  localparam logic [11:0] IRQ_EN_ADDR   = 12'h102;

  // Field positions
  localparam int unsigned TM_MSB         = 15;
  localparam int unsigned TM_LSB         = 13;
  localparam int unsigned SRST_BIT       = 15;
  localparam int unsigned LOOP_BIT       = 14;
  localparam int unsigned TXLPI_LAT_BIT  = 11;
  localparam int unsigned RXLPI_LAT_BIT  = 10;
  localparam int unsigned TXLPI_LIVE_BIT = 9;
  localparam int unsigned RXLPI_LIVE_BIT = 8;
  localparam int unsigned FAULT_BIT      = 7;
  localparam int unsigned LINK_BIT       = 2;

  localparam int unsigned IRQ_TXLPI = 0;
  localparam int unsigned IRQ_RXLPI = 1;
  localparam int unsigned IRQ_FAULT = 2;
  localparam int unsigned IRQ_LINK  = 3;
  localparam int unsigned IRQ_W     = 4;
  localparam int unsigned LAT_N     = 3;

  // Test mode codes
  localparam logic [2:0] TM_NORMAL = 3'h0;
  localparam logic [2:0] TM_MODE1  = 3'h1;
  localparam logic [2:0] TM_MODE2  = 3'h2;
  localparam logic [2:0] TM_MODE3  = 3'h3;

  // Reset values
  localparam logic [2:0]       TM_RST   = 3'h0;
  localparam logic             BIT_RST  = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_RST  = 4'h0;
  localparam logic [15:0]      RD_RST   = 16'h0000;

  // Soft reset hold time
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SRST_TIME_NS  = 100;
  localparam int unsigned SRST_CYCLES   =
    (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SRST_CNT_W    = 8;

  typedef enum logic [0:0] {
    PCR_SRST_IDLE,
    PCR_SRST_HOLD
  } pcr_srst_state_t;

endpackage : pcr_pkg

// ===== logic/pcr_regs.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
// Functional notes
// - Bits 15:13 of test_pattern_select pick normal, test mode 1, 2 or 3; codes with bit 15 set are reserved.
// - Writing 1 to control bit 15 resets the coding sublayer; the bit self-clears and 0 is normal.
// - Control bit 14 is a read-write loopback enable.
// - Status bit 11 latches transmit low-power idle until software writes zero to it.
// - Status bit 10 latches receive low-power idle until software writes zero to it.
// - Status bit 9 shows transmit low-power idle live.
// - Status bit 8 shows receive low-power idle live.
// - Status bit 7 latches a coding-sublayer fault until software writes zero to it.
// - Status bit 2 reports receive link up or down and is set by writing zero while the link is up.
module pcr_regs
  import pcr_pkg::*;
(
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_RST,
  input  wire logic [ADDR_W-1:0] I_ADDR,
  input  wire logic [DATA_W-1:0] I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  output logic      [DATA_W-1:0] O_RDATA,
  input  wire logic              I_TX_LPI,
  input  wire logic              I_RX_LPI,
  input  wire logic              I_FAULT,
  input  wire logic              I_LINK_UP,
  output logic      [2:0]        O_TEST_MODE,
  output logic                   O_PCS_SRST,
  output logic                   O_PCS_LOOP,
  output logic                   O_IRQ
);

  // Host addresses arrive with the group tag already stripped
  localparam logic [ADDR_W-1:0] TMS_ADDR = TMS_OFFSET[ADDR_W-1:0];
  localparam logic [ADDR_W-1:0] CSC_ADDR = CSC_OFFSET[ADDR_W-1:0];
  localparam logic [ADDR_W-1:0] CSA_ADDR = CSA_OFFSET[ADDR_W-1:0];
  localparam logic [ADDR_W-1:0] CSS_ADDR = CSS_OFFSET[ADDR_W-1:0];

  pcr_srst_if srst_if ();

  logic              sel_tms;
  logic              sel_ctl;
  logic              sel_css;
  logic              sel_ist;
  logic              sel_icl;
  logic              sel_ien;
  logic              wr_tms;
  logic              wr_ctl;
  logic              wr_css;
  logic              wr_icl;
  logic              wr_ien;

  logic [2:0]        tm_r;
  logic [2:0]        tm_nxt;
  logic [2:0]        tm_out_r;
  logic [2:0]        tm_out_nxt;
  logic              loop_r;
  logic              loop_nxt;

  logic [LAT_N-1:0]  lat_r;
  logic [LAT_N-1:0]  lat_set;
  logic [LAT_N-1:0]  lat_wbit;
  logic              link_r;
  logic              link_nxt;
  logic              link_prev_r;
  logic              link_prev_nxt;

  logic [IRQ_W-1:0]  ist_r;
  logic [IRQ_W-1:0]  ist_nxt;
  logic [IRQ_W-1:0]  ien_r;
  logic [IRQ_W-1:0]  ien_nxt;
  logic [IRQ_W-1:0]  irq_evt;

  logic [DATA_W-1:0] rd_r;
  logic [DATA_W-1:0] rd_nxt;
  logic [DATA_W-1:0] ctl_view;
  logic [DATA_W-1:0] css_view;

  // Address decode
  always_comb begin
    sel_tms = (I_ADDR == TMS_ADDR);
    sel_ctl = (I_ADDR == CSC_ADDR) || (I_ADDR == CSA_ADDR);
    sel_css = (I_ADDR == CSS_ADDR);
    sel_ist = (I_ADDR == IRQ_STAT_ADDR);
    sel_icl = (I_ADDR == IRQ_CLR_ADDR);
    sel_ien = (I_ADDR == IRQ_EN_ADDR);
    wr_tms  = I_WR && sel_tms;
    wr_ctl  = I_WR && sel_ctl;
    wr_css  = I_WR && sel_css;
    wr_icl  = I_WR && sel_icl;
    wr_ien  = I_WR && sel_ien;
  end

  // Test pattern selector
  always_comb begin
    tm_nxt = tm_r;
    if (wr_tms) begin
      tm_nxt = I_WDATA[TM_MSB:TM_LSB];
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      tm_r <= TM_RST;
    end else begin
      tm_r <= tm_nxt;
    end
  end

  // Reserved codes read back as written but drive normal operation
  always_comb begin
    case (tm_nxt)
      TM_MODE1: tm_out_nxt = TM_MODE1;
      TM_MODE2: tm_out_nxt = TM_MODE2;
      TM_MODE3: tm_out_nxt = TM_MODE3;
      default:  tm_out_nxt = TM_NORMAL;
    endcase
  end

  // Decoded from the next value so the pins follow the write at once
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      tm_out_r <= TM_RST;
    end else begin
      tm_out_r <= tm_out_nxt;
    end
  end

  // Coding-sublayer control, shared by both control addresses
  always_comb begin
    loop_nxt = loop_r;
    if (wr_ctl) begin
      loop_nxt = I_WDATA[LOOP_BIT];
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      loop_r <= BIT_RST;
    end else begin
      loop_r <= loop_nxt;
    end
  end

  // Writing 0 to the reset bit is a no-op, never an abort
  assign srst_if.start = wr_ctl && I_WDATA[SRST_BIT];

  pcr_srst_seq u_srst (
    .i_clk (I_CORE_CLK),
    .i_rst (I_RST),
    .sif   (srst_if.seq)
  );

  // Sticky status bits: hardware set beats software clear
  assign lat_set  = {I_TX_LPI, I_RX_LPI, I_FAULT};
  assign lat_wbit = {I_WDATA[TXLPI_LAT_BIT],
                     I_WDATA[RXLPI_LAT_BIT],
                     I_WDATA[FAULT_BIT]};

  genvar gi;
  generate
    for (gi = 0; gi < LAT_N; gi++) begin : g_lat
      logic lat_nxt;
      always_comb begin
        lat_nxt = lat_r[gi];
        if (wr_css && !lat_wbit[gi]) begin
          lat_nxt = 1'b0;
        end
        if (lat_set[gi]) begin
          lat_nxt = 1'b1;
        end
      end
      always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
          lat_r[gi] <= BIT_RST;
        end else begin
          lat_r[gi] <= lat_nxt;
        end
      end
    end
  endgenerate

  // Link bit latches low on loss; a zero write re-arms it when up
  always_comb begin
    link_nxt = link_r;
    if (wr_css && !I_WDATA[LINK_BIT]) begin
      link_nxt = I_LINK_UP;
    end
    if (!I_LINK_UP) begin
      link_nxt = 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      link_r <= BIT_RST;
    end else begin
      link_r <= link_nxt;
    end
  end

  // Resets low, so a link that is down out of reset gives no false loss event
  always_comb begin
    link_prev_nxt = I_LINK_UP;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      link_prev_r <= BIT_RST;
    end else begin
      link_prev_r <= link_prev_nxt;
    end
  end

  // Interrupt status: events set, ones written to the clear address drop
  always_comb begin
    irq_evt            = '0;
    irq_evt[IRQ_TXLPI] = I_TX_LPI && !lat_r[2];
    irq_evt[IRQ_RXLPI] = I_RX_LPI && !lat_r[1];
    irq_evt[IRQ_FAULT] = I_FAULT && !lat_r[0];
    irq_evt[IRQ_LINK]  = link_prev_r && !I_LINK_UP;
    ist_nxt = ist_r;
    if (wr_icl) begin
      ist_nxt = ist_r & ~I_WDATA[IRQ_W-1:0];
    end
    // Set after clear, so an event in the clear cycle is not lost
    ist_nxt = ist_nxt | irq_evt;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ist_r <= IRQ_RST;
    end else begin
      ist_r <= ist_nxt;
    end
  end

  // Interrupt enable
  always_comb begin
    ien_nxt = ien_r;
    if (wr_ien) begin
      ien_nxt = I_WDATA[IRQ_W-1:0];
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ien_r <= IRQ_RST;
    end else begin
      ien_r <= ien_nxt;
    end
  end

  // Read views
  always_comb begin
    ctl_view                 = '0;
    ctl_view[SRST_BIT]       = srst_if.busy;
    ctl_view[LOOP_BIT]       = loop_r;
    css_view                 = '0;
    css_view[TXLPI_LAT_BIT]  = lat_r[2];
    css_view[RXLPI_LAT_BIT]  = lat_r[1];
    css_view[TXLPI_LIVE_BIT] = I_TX_LPI;
    css_view[RXLPI_LIVE_BIT] = I_RX_LPI;
    css_view[FAULT_BIT]      = lat_r[0];
    css_view[LINK_BIT]       = link_r;
  end

  // Read data stand only in the cycle after the strobe
  always_comb begin
    rd_nxt = '0;
    if (I_RD) begin
      if (sel_tms) begin
        rd_nxt[TM_MSB:TM_LSB] = tm_r;
      end else if (sel_ctl) begin
        rd_nxt = ctl_view;
      end else if (sel_css) begin
        rd_nxt = css_view;
      end else if (sel_ist) begin
        rd_nxt[IRQ_W-1:0] = ist_r;
      end else if (sel_ien) begin
        rd_nxt[IRQ_W-1:0] = ien_r;
      end else begin
        rd_nxt = RD_RST;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      rd_r <= RD_RST;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign O_RDATA     = rd_r;
  assign O_TEST_MODE = tm_out_r;
  assign O_PCS_SRST  = srst_if.rst;
  assign O_PCS_LOOP  = loop_r;
  assign O_IRQ       = |(ist_r & ien_r);

endmodule : pcr_regs

// ===== logic/pcr_srst_if.sv
`timescale 1ns/10ps
interface pcr_srst_if;
  logic start;
  logic busy;
  logic rst;

  modport ctl (output start, input busy, input rst);
  modport seq (input start, output busy, output rst);
endinterface : pcr_srst_if

// ===== logic/pcr_srst_seq.sv
`timescale 1ns/10ps
module pcr_srst_seq
  import pcr_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  pcr_srst_if.seq   sif
);

  pcr_srst_state_t       state_r;
  pcr_srst_state_t       state_nxt;
  logic [SRST_CNT_W-1:0] cnt_r;
  logic [SRST_CNT_W-1:0] cnt_nxt;
  logic                  rst_r;
  logic                  rst_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    rst_nxt   = rst_r;
    case (state_r)
      PCR_SRST_IDLE: begin
        // Start while holding is ignored
        if (sif.start) begin
          state_nxt = PCR_SRST_HOLD;
          cnt_nxt   = SRST_CNT_W'(SRST_CYCLES - 1);
          rst_nxt   = 1'b1;
        end
      end
      PCR_SRST_HOLD: begin
        if (cnt_r == '0) begin
          state_nxt = PCR_SRST_IDLE;
          rst_nxt   = 1'b0;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: begin
        state_nxt = PCR_SRST_IDLE;
        cnt_nxt   = '0;
        rst_nxt   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= PCR_SRST_IDLE;
      cnt_r   <= '0;
      rst_r   <= BIT_RST;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      rst_r   <= rst_nxt;
    end
  end

  assign sif.rst  = rst_r;
  assign sif.busy = rst_r;

endmodule : pcr_srst_seq

// ===== sim/pcr_regs_asserts.sv
`timescale 1ns/10ps
module pcr_regs_asserts
  import pcr_pkg::*;
(
  input wire logic              I_CORE_CLK,
  input wire logic              I_RST,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [DATA_W-1:0] I_WDATA,
  input wire logic              I_WR,
  input wire logic              I_RD,
  input wire logic [DATA_W-1:0] O_RDATA,
  input wire logic              I_TX_LPI,
  input wire logic              I_RX_LPI,
  input wire logic              I_FAULT,
  input wire logic              I_LINK_UP,
  input wire logic [2:0]        O_TEST_MODE,
  input wire logic              O_PCS_SRST,
  input wire logic              O_PCS_LOOP,
  input wire logic              O_IRQ
);
  logic tm_wr;
  logic ctl_wr;
  logic st_rd;
  logic st_wr;
  assign tm_wr  = I_WR && (I_ADDR == 12'h8f8);
  assign ctl_wr = I_WR && (I_ADDR == 12'h000 || I_ADDR == 12'h8e6);
  assign st_rd  = I_RD && (I_ADDR == 12'h8e7);
  assign st_wr  = I_WR && (I_ADDR == 12'h8e7);

  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);

  // Reserved codes must never reach the transmitter
  property p_tm;
    logic [2:0] v;
    (tm_wr, v = I_WDATA[15:13]) |=> O_TEST_MODE == (v[2] ? 3'h0 : v);
  endproperty
  a_tm: assert property (p_tm) else $error("test mode output wrong");

  property p_srst_go;
    ctl_wr && I_WDATA[15] && !O_PCS_SRST |=> O_PCS_SRST;
  endproperty
  a_srst_go: assert property (p_srst_go) else $error("soft reset missing");

  property p_srst_len;
    $rose(O_PCS_SRST) |-> O_PCS_SRST[*8] ##1 O_PCS_SRST ##1 O_PCS_SRST
      ##1 !O_PCS_SRST;
  endproperty
  a_srst_len: assert property (p_srst_len) else $error("soft reset length");

  property p_loop;
    logic v;
    (ctl_wr, v = I_WDATA[14]) |=> O_PCS_LOOP == v;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback not loaded");

  property p_loop_hold;
    !ctl_wr |=> $stable(O_PCS_LOOP);
  endproperty
  a_loop_hold: assert property (p_loop_hold) else $error("loopback moved");

  property p_live;
    st_rd |=> O_RDATA[9] == $past(I_TX_LPI) && O_RDATA[8] == $past(I_RX_LPI);
  endproperty
  a_live: assert property (p_live) else $error("live idle bits wrong");

  property p_fault;
    I_FAULT ##1 !st_wr ##1 st_rd |=> O_RDATA[7];
  endproperty
  a_fault: assert property (p_fault) else $error("fault not latched");

  property p_link0;
    !I_LINK_UP ##1 st_rd |=> !O_RDATA[2];
  endproperty
  a_link0: assert property (p_link0) else $error("link shown up");
endmodule : pcr_regs_asserts

// ===== sim/pcr_regs_tb.sv
`timescale 1ns/10ps
module pcr_regs_tb;
  import pcr_pkg::*;
  logic        clk = 0, rst = 1, wr = 0, rd = 0;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000;
  logic        tx_lpi = 0, rx_lpi = 0, fault = 0, link_up = 0;
  logic [15:0] rdata;
  logic [2:0]  test_mode;
  logic        srst, loop_en, irq;
  int          errors = 0, n_compared = 0, n;

  always #5 clk = ~clk;

  pcr_regs u_pcr_regs (.I_CORE_CLK(clk), .I_RST(rst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_TX_LPI(tx_lpi), .I_RX_LPI(rx_lpi), .I_FAULT(fault),
    .I_LINK_UP(link_up), .O_TEST_MODE(test_mode), .O_PCS_SRST(srst),
    .O_PCS_LOOP(loop_en), .O_IRQ(irq));

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(logic [11:0] a, logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  // Data stands only in the cycle after the strobe
  task automatic rd_reg(logic [11:0] a, logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), rdata, exp);
  endtask : rd_reg

  // Order of v: tx_lpi, rx_lpi, fault, link_up
  task automatic drive(logic [3:0] v);
    @(posedge clk);
    {tx_lpi, rx_lpi, fault, link_up} <= v;
  endtask : drive

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    results;
  end

  initial begin
    static logic [11:0] a_list [7] = '{12'h8f8, 12'h000, 12'h8e6, 12'h8e7,
                                12'h100, 12'h102, 12'h123};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (a_list[i]) rd_reg(a_list[i], 16'h0000);
    chk("outputs", 16'({irq, loop_en, srst, test_mode}), 16'h0000);
    wr_reg(12'h123, 16'hffff);
    rd_reg(12'h123, 16'h0000);
    $display("reset values done");

    for (int c = 0; c < 8; c++) begin
      wr_reg(12'h8f8, {3'(c), 13'h1fff});
      chk("test mode", 16'(test_mode), c[2] ? 16'h0 : 16'(c));
      rd_reg(12'h8f8, {3'(c), 13'h0000});
    end
    $display("test mode done");

    wr_reg(12'h000, 16'h4000);
    chk("loop", 16'(loop_en), 16'h1);
    rd_reg(12'h8e6, 16'h4000);
    wr_reg(12'h8e6, 16'h0000);
    chk("loop", 16'(loop_en), 16'h0);
    $display("loopback done");

    wr_reg(12'h8e6, 16'h8000);
    rd_reg(12'h000, 16'h8000);
    n = 2;
    while (srst && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("srst cycles", 16'(n), 16'(SRST_CYCLES));
    rd_reg(12'h000, 16'h0000);
    $display("soft reset done");

    drive(4'b1000);
    drive(4'b1100);
    drive(4'b1110);
    drive(4'b1100);
    rd_reg(12'h8e7, 16'h0f80);
    drive(4'b0100);
    drive(4'b0000);
    rd_reg(12'h8e7, 16'h0c80);
    // Ones must leave the sticky bits alone
    wr_reg(12'h8e7, 16'h0400);
    rd_reg(12'h8e7, 16'h0400);
    $display("status done");

    drive(4'b0001);
    rd_reg(12'h8e7, 16'h0400);
    wr_reg(12'h8e7, 16'h0000);
    rd_reg(12'h8e7, 16'h0004);
    wr_reg(12'h8e7, 16'h0004);
    rd_reg(12'h8e7, 16'h0004);
    drive(4'b0000);
    rd_reg(12'h8e7, 16'h0000);
    $display("link done");

    rd_reg(12'h100, 16'h000f);
    wr_reg(12'h101, 16'h000f);
    rd_reg(12'h100, 16'h0000);
    wr_reg(12'h102, 16'h0004);
    rd_reg(12'h102, 16'h0004);
    drive(4'b0100);
    drive(4'b0000);
    @(posedge clk);
    #1;
    chk("irq masked", 16'(irq), 16'h0);
    drive(4'b0010);
    drive(4'b0000);
    rd_reg(12'h100, 16'h0006);
    chk("irq", 16'(irq), 16'h1);
    wr_reg(12'h101, 16'h0004);
    rd_reg(12'h100, 16'h0002);
    chk("irq cleared", 16'(irq), 16'h0);
    $display("interrupt done");
    results;
  end
endmodule : pcr_regs_tb

bind pcr_regs pcr_regs_asserts u_pcr_regs_asserts (
  .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .I_TX_LPI(I_TX_LPI), .I_RX_LPI(I_RX_LPI), .I_FAULT(I_FAULT),
  .I_LINK_UP(I_LINK_UP), .O_TEST_MODE(O_TEST_MODE),
  .O_PCS_SRST(O_PCS_SRST), .O_PCS_LOOP(O_PCS_LOOP), .O_IRQ(O_IRQ));
